/* hw/swsr_pkg.sv */
package swsr_pkg;

    // Clock rate and line timing, times in microseconds, then in clock cycles
    localparam int CLK_MHZ = 250;
    localparam int RESET_LOW_US = 480;
    localparam int SAMPLE_US = 30;
    localparam int PRES_WAIT_US = 30;
    localparam int PRES_LEN_US = 120;
    localparam int CONV_MAX_US = 750000;
    localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
    localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
    localparam int PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
    localparam int PRES_LEN_CYC = PRES_LEN_US * CLK_MHZ;
    localparam int CONV_MAX_CYC = CONV_MAX_US * CLK_MHZ;
    localparam logic [4:0] RECALL_CYC = 5'h10;

    // Counter widths
    localparam int TW = 17;
    localparam int CVW = 28;

    // ROM commands
    localparam logic [7:0] CMD_SEARCH = 8'hf0;
    localparam logic [7:0] CMD_READ_ID = 8'h33;
    localparam logic [7:0] CMD_MATCH = 8'h55;
    localparam logic [7:0] CMD_SKIP = 8'hcc;
    localparam logic [7:0] CMD_ALARM_SEARCH = 8'hec;
    // Function commands
    localparam logic [7:0] CMD_CONVERT = 8'h44;
    localparam logic [7:0] CMD_WRITE_SP = 8'h4e;
    localparam logic [7:0] CMD_READ_SP = 8'hbe;
    localparam logic [7:0] CMD_COPY_SP = 8'h48;
    localparam logic [7:0] CMD_RELOAD_NV = 8'hb8;
    localparam logic [7:0] CMD_POWER = 8'hb4;

    // Scratchpad byte offsets
    localparam int SP_TEMP_LO = 0;
    localparam int SP_TEMP_HI = 1;
    localparam int SP_UPPER = 2;
    localparam int SP_LOWER = 3;
    localparam int SP_CONFIG = 4;
    localparam int SP_CHECK = 8;

    // Last bit index of each transfer
    localparam logic [6:0] LAST_CMD = 7'h07;
    localparam logic [6:0] LAST_WR = 7'h17;
    localparam logic [6:0] LAST_ID = 7'h3f;
    localparam logic [6:0] LAST_SP = 7'h47;

    // Configuration byte layout and reset values
    localparam int CFG_SEL_LSB = 5;
    localparam logic CFG_TOP_BIT = 1'b0;
    localparam logic [4:0] CFG_LOW_BITS = 5'h1f;
    localparam logic [1:0] NV_SEL_RESET = 2'h3;
    localparam logic [7:0] NV_UPPER_RESET = 8'h4b;
    localparam logic [7:0] NV_LOWER_RESET = 8'h46;
    localparam logic [15:0] TEMP_RESET = 16'h0550;
    localparam logic [7:0] RSVD_A = 8'hff;
    localparam logic [7:0] RSVD_B = 8'h00;
    localparam logic [7:0] RSVD_C = 8'h10;

    // Reflected form of x^8 + x^5 + x^4 + 1
    localparam logic [7:0] CRC_POLY = 8'h8c;

    // Check byte over the low nbits of data, shifted in lsb first
    function automatic logic [7:0] swsr_crc(input logic [63:0] data, input int nbits);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 0; i < 64; i++) begin
            if (i < nbits) begin
                fb = c[0] ^ data[i];
                c = {1'b0, c[7:1]} ^ (fb ? CRC_POLY : 8'h00);
            end
        end
        return c;
    endfunction : swsr_crc

    typedef enum logic [3:0] {
        PH_IDLE, PH_PRES_WAIT, PH_PRES_DRIVE, PH_ROM_CMD, PH_READ_ID, PH_MATCH,
        PH_SEARCH, PH_FUNC_CMD, PH_WRITE_SP, PH_READ_SP, PH_STATUS, PH_POWER
    } swsr_phase_e;

endpackage : swsr_pkg

/* hw/swsr_device.sv */
`timescale 1ns/1ns
module swsr_device
    import swsr_pkg::*;
#(
    parameter logic [7:0] FAMILY_CODE = 8'h5a,        // Arbitrary value
    parameter logic [47:0] SERIAL = 48'h0123456789ab, // Arbitrary value
    parameter int RESET_LOW_CYCLES = RESET_LOW_CYC,
    parameter int SAMPLE_CYCLES = SAMPLE_CYC,
    parameter int PRES_WAIT_CYCLES = PRES_WAIT_CYC,
    parameter int PRES_LEN_CYCLES = PRES_LEN_CYC,
    parameter int CONV_MAX_CYCLES = CONV_MAX_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe,
    input wire logic ext_powered,
    input wire logic [15:0] temp_in,
    input wire logic temp_valid,
    output logic conv_start,
    output logic [1:0] resolution_sel,
    output logic alarm_flag
);

    // Identifier with its check byte over the low 56 bits
    localparam logic [63:0] ID = {swsr_crc({8'h00, SERIAL, FAMILY_CODE}, 56),
                                  SERIAL, FAMILY_CODE};

    typedef struct packed {
        logic dq_m;
        logic dq_s;
        logic dq_d;
        logic pw_m;
        logic pw_s;
        swsr_phase_e ph;
        logic [TW-1:0] low_cnt;
        logic [TW-1:0] tcnt;
        logic slot_act;
        logic oe;
        logic drv;
        logic [71:0] sh;
        logic [6:0] nb;
        logic [1:0] sub;
        logic [15:0] temp;
        logic [7:0] upper;
        logic [7:0] lower;
        logic [1:0] sel;
        logic [7:0] nv_upper;
        logic [7:0] nv_lower;
        logic [1:0] nv_sel;
        logic [4:0] recall_cnt;
        logic [CVW-1:0] conv_cnt;
        logic conv_start;
        logic alarm;
    } swsr_state_s;

    swsr_state_s r;
    swsr_state_s next_r;
    logic rst_m;
    logic rst_s;
    logic [7:0] cfg_byte;
    logic [63:0] sp_img;
    logic [7:0] sp_crc;
    logic [71:0] sh_in;
    logic data_phase;
    logic tx_mode;
    logic tx_bit;
    logic slot_start;
    logic bit_done;
    logic bus_reset;

    // Conversion limit halves per resolution step below twelve bits
    function automatic logic [CVW-1:0] conv_limit(input logic [1:0] sel);
        return CVW'(CONV_MAX_CYCLES) >> (2'h3 - sel);
    endfunction : conv_limit

    // Reset release through two flops so every state flop leaves reset together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    // Scratchpad image; fixed configuration bits come from constants
    assign cfg_byte = {CFG_TOP_BIT, r.sel, CFG_LOW_BITS};
    assign sp_img = {RSVD_C, RSVD_B, RSVD_A, cfg_byte, r.lower, r.upper, r.temp};
    assign sp_crc = swsr_crc(sp_img, 64);
    // Every received bit enters at the top, so bytes land lsb first
    assign sh_in = {r.dq_s, r.sh[71:1]};
    assign data_phase = (r.ph >= PH_ROM_CMD);
    assign bus_reset = !r.dq_s && (int'(r.low_cnt) >= RESET_LOW_CYCLES);

    // Which phases drive read slots and what bit they send
    always_comb begin
        tx_mode = 1'b0;
        tx_bit = r.sh[0];
        unique case (r.ph)
            PH_READ_ID, PH_READ_SP: tx_mode = 1'b1;
            PH_SEARCH: begin
                tx_mode = (r.sub != 2'h2);
                tx_bit = (r.sub == 2'h1) ? ~r.sh[0] : r.sh[0];
            end
            PH_STATUS: begin
                tx_mode = 1'b1;
                // Busy reads 0, done reads 1
                tx_bit = r.sub[0] ? (r.recall_cnt == 5'h00) : (r.conv_cnt == '0);
            end
            PH_POWER: begin
                tx_mode = 1'b1;
                tx_bit = r.pw_s;
            end
            default: begin
                tx_mode = 1'b0;
                tx_bit = r.sh[0];
            end
        endcase
    end

    // Whole next state
    always_comb begin
        next_r = r;
        slot_start = 1'b0;
        bit_done = 1'b0;
        next_r.dq_m = dq_in;
        next_r.dq_s = r.dq_m;
        next_r.dq_d = r.dq_s;
        next_r.pw_m = ext_powered;
        next_r.pw_s = r.pw_m;
        next_r.conv_start = 1'b0;

        // Conversion timer; the converter's result ends it early
        if (r.conv_cnt != '0) begin
            next_r.conv_cnt = r.conv_cnt - CVW'(1);
        end
        if (temp_valid) begin
            next_r.temp = temp_in;
            next_r.conv_cnt = '0;
            next_r.alarm = ($signed(temp_in[11:4]) <= $signed(r.lower)) ||
                           ($signed(temp_in[11:4]) >= $signed(r.upper));
        end

        // Reload from nonvolatile copy when the recall delay runs out
        if (r.recall_cnt != 5'h00) begin
            next_r.recall_cnt = r.recall_cnt - 5'h01;
            if (r.recall_cnt == 5'h01) begin
                next_r.upper = r.nv_upper;
                next_r.lower = r.nv_lower;
                next_r.sel = r.nv_sel;
            end
        end

        // Low-time counter saturates at the bus reset threshold
        if (!r.dq_s) begin
            if (int'(r.low_cnt) < RESET_LOW_CYCLES) begin
                next_r.low_cnt = r.low_cnt + TW'(1);
            end
        end else begin
            next_r.low_cnt = '0;
        end

        // Slot layer: a master falling edge opens a slot, one sample point closes it.
        // Idle-high time between slots is not timed, so gaps of any length are fine.
        if (data_phase && !r.slot_act && r.dq_d && !r.dq_s) begin
            slot_start = 1'b1;
            next_r.slot_act = 1'b1;
            next_r.tcnt = '0;
            next_r.oe = tx_mode && !tx_bit;
        end else if (r.slot_act) begin
            if (int'(r.tcnt) == SAMPLE_CYCLES - 1) begin
                next_r.slot_act = 1'b0;
                next_r.oe = 1'b0;
                bit_done = 1'b1;
            end else begin
                next_r.tcnt = r.tcnt + TW'(1);
            end
        end

        // Protocol layer
        unique case (r.ph)
            PH_IDLE: begin
                next_r.oe = 1'b0;
            end
            PH_PRES_WAIT: begin
                next_r.tcnt = r.tcnt + TW'(1);
                if (int'(r.tcnt) == PRES_WAIT_CYCLES - 1) begin
                    next_r.tcnt = '0;
                    next_r.oe = 1'b1;
                    next_r.ph = PH_PRES_DRIVE;
                end
            end
            PH_PRES_DRIVE: begin
                next_r.tcnt = r.tcnt + TW'(1);
                if (int'(r.tcnt) == PRES_LEN_CYCLES - 1) begin
                    next_r.tcnt = '0;
                    next_r.oe = 1'b0;
                    next_r.nb = '0;
                    next_r.ph = PH_ROM_CMD;
                end
            end
            PH_ROM_CMD: begin
                if (bit_done) begin
                    next_r.sh = sh_in;
                    next_r.nb = r.nb + 7'h01;
                    if (r.nb == LAST_CMD) begin
                        next_r.nb = '0;
                        next_r.sub = 2'h0;
                        next_r.sh = {8'h00, ID};
                        unique case (sh_in[71:64])
                            CMD_READ_ID: next_r.ph = PH_READ_ID;
                            CMD_MATCH: next_r.ph = PH_MATCH;
                            CMD_SKIP: next_r.ph = PH_FUNC_CMD;
                            CMD_SEARCH: next_r.ph = PH_SEARCH;
                            CMD_ALARM_SEARCH: next_r.ph = r.alarm ? PH_SEARCH : PH_IDLE;
                            default: next_r.ph = PH_IDLE;
                        endcase
                    end
                end
            end
            PH_READ_ID: begin
                if (bit_done) begin
                    next_r.sh = sh_in;
                    next_r.nb = r.nb + 7'h01;
                    if (r.nb == LAST_ID) begin
                        next_r.nb = '0;
                        next_r.ph = PH_FUNC_CMD;
                    end
                end
            end
            PH_MATCH: begin
                if (bit_done) begin
                    next_r.sh = sh_in;
                    next_r.nb = r.nb + 7'h01;
                    if (r.nb == LAST_ID) begin
                        next_r.nb = '0;
                        // A mismatch waits silently for the next reset pulse
                        next_r.ph = (sh_in[71:8] == ID) ? PH_FUNC_CMD : PH_IDLE;
                    end
                end
            end
            PH_SEARCH: begin
                // Bit, complement, then the master's choice per identifier bit
                if (bit_done) begin
                    next_r.sub = r.sub + 2'h1;
                    if (r.sub == 2'h2) begin
                        next_r.sub = 2'h0;
                        next_r.sh = sh_in;
                        next_r.nb = r.nb + 7'h01;
                        // A search always ends the access, found or not
                        if (r.dq_s != r.sh[0] || r.nb == LAST_ID) begin
                            next_r.ph = PH_IDLE;
                        end
                    end
                end
            end
            PH_FUNC_CMD: begin
                if (bit_done) begin
                    next_r.sh = sh_in;
                    next_r.nb = r.nb + 7'h01;
                    if (r.nb == LAST_CMD) begin
                        next_r.nb = '0;
                        unique case (sh_in[71:64])
                            CMD_CONVERT: begin
                                next_r.conv_start = 1'b1;
                                next_r.conv_cnt = conv_limit(r.sel);
                                next_r.sub = 2'h0;
                                next_r.ph = PH_STATUS;
                            end
                            CMD_WRITE_SP: next_r.ph = PH_WRITE_SP;
                            CMD_READ_SP: begin
                                next_r.sh = {sp_crc, sp_img};
                                next_r.ph = PH_READ_SP;
                            end
                            CMD_COPY_SP: begin
                                next_r.nv_upper = r.upper;
                                next_r.nv_lower = r.lower;
                                next_r.nv_sel = r.sel;
                                next_r.ph = PH_IDLE;
                            end
                            CMD_RELOAD_NV: begin
                                next_r.recall_cnt = RECALL_CYC;
                                next_r.sub = 2'h1;
                                next_r.ph = PH_STATUS;
                            end
                            CMD_POWER: next_r.ph = PH_POWER;
                            default: next_r.ph = PH_IDLE;
                        endcase
                    end
                end
            end
            PH_WRITE_SP: begin
                if (bit_done) begin
                    next_r.sh = sh_in;
                    next_r.nb = r.nb + 7'h01;
                    // Commit only once all three bytes are in; a cut-off write is dropped
                    if (r.nb == LAST_WR) begin
                        next_r.upper = sh_in[55:48];
                        next_r.lower = sh_in[63:56];
                        next_r.sel = sh_in[64 + CFG_SEL_LSB +: 2];
                        next_r.ph = PH_IDLE;
                    end
                end
            end
            PH_READ_SP: begin
                // No check on what the master makes of the data; it may reset at will
                if (bit_done) begin
                    next_r.sh = sh_in;
                    next_r.nb = r.nb + 7'h01;
                    if (r.nb == LAST_SP) begin
                        next_r.ph = PH_IDLE;
                    end
                end
            end
            PH_STATUS, PH_POWER: begin
                next_r.nb = '0;
            end
        endcase

        // Long low abandons the transaction and any open slot; its rising edge starts the presence answer
        if (bus_reset) begin
            next_r.ph = PH_IDLE;
            next_r.slot_act = 1'b0;
            next_r.oe = 1'b0;
        end else if (r.dq_s && int'(r.low_cnt) >= RESET_LOW_CYCLES) begin
            next_r.ph = PH_PRES_WAIT;
            next_r.slot_act = 1'b0;
            next_r.tcnt = '0;
            next_r.oe = 1'b0;
        end
    end

    // State register; power-up loads scratchpad from nonvolatile defaults
    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            r <= '0;
            r.dq_m <= 1'b1;
            r.dq_s <= 1'b1;
            r.dq_d <= 1'b1;
            r.pw_m <= 1'b1;
            r.pw_s <= 1'b1;
            r.ph <= PH_IDLE;
            r.temp <= TEMP_RESET;
            r.upper <= NV_UPPER_RESET;
            r.lower <= NV_LOWER_RESET;
            r.sel <= NV_SEL_RESET;
            r.nv_upper <= NV_UPPER_RESET;
            r.nv_lower <= NV_LOWER_RESET;
            r.nv_sel <= NV_SEL_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Pin only ever pulls low; the enable alone decides the wire
    assign dq_out = r.drv;
    assign dq_oe = r.oe;
    assign conv_start = r.conv_start;
    assign resolution_sel = r.sel;
    assign alarm_flag = r.alarm;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_s);

    sequence pres_begin_s;
        r.ph == PH_PRES_WAIT ##1 r.ph == PH_PRES_DRIVE;
    endsequence
    sequence write_done_s;
        r.ph == PH_WRITE_SP && bit_done && r.nb == LAST_WR;
    endsequence
    sequence read_sp_cmd_s;
        r.ph == PH_FUNC_CMD && bit_done && r.nb == LAST_CMD && sh_in[71:64] == CMD_READ_SP;
    endsequence

    presence_drive_a: assert property (pres_begin_s |-> r.oe [*8])
        else $error("presence pulse not driven");
    write_commit_a: assert property (write_done_s |=> r.ph == PH_IDLE &&
        r.sel == $past(sh_in[70:69]) && r.upper == $past(sh_in[55:48]))
        else $error("write data not stored in order");
    cfg_fixed_a: assert property (sp_img[39:32] == {1'b0, resolution_sel, 5'h1f})
        else $error("configuration fixed bits wrong");
    bus_reset_a: assert property (bus_reset |=> r.ph == PH_IDLE && !dq_oe)
        else $error("long low did not abandon transaction");
    read_sp_load_a: assert property (read_sp_cmd_s |=>
        r.sh[71:64] == $past(sp_crc) && r.sh[15:0] == $past(r.temp))
        else $error("scratchpad image not loaded for read");
    match_miss_a: assert property (r.ph == PH_MATCH && bit_done && r.nb == LAST_ID &&
        sh_in[71:8] != ID |=> r.ph == PH_IDLE)
        else $error("mismatching match kept device selected");
    search_drop_a: assert property (r.ph == PH_SEARCH && r.sub == 2'h2 && bit_done &&
        r.dq_s != r.sh[0] |=> r.ph == PH_IDLE)
        else $error("search loser did not drop out");
    recall_busy_a: assert property (slot_start && r.ph == PH_STATUS && r.sub[0] &&
        r.recall_cnt > 5'h01 |=> dq_oe)
        else $error("recall busy did not read zero");
    conv_limit_a: assert property (conv_start |-> r.conv_cnt == conv_limit($past(r.sel)))
        else $error("conversion limit wrong for resolution");
    slot_release_a: assert property (bit_done |=> !dq_oe)
        else $error("line held past sample point");

endmodule : swsr_device

/* tb/swsr_bus_master.sv */
`timescale 1ns/1ns
module swsr_bus_master (
    input wire logic clk,
    input wire logic dq,
    output logic m_oe
);
    // Pulls the wire low only while m_oe is high; released otherwise
    initial m_oe = 1'b0;

    // Drive a level and keep it for n falling edges
    task automatic hold(input logic lvl, input int n);
        m_oe = lvl;
        repeat (n) @(negedge clk);
    endtask : hold

    // Long low is a bus reset; presence sampled mid-window
    task automatic bus_reset(output logic present);
        hold(1'b1, 220);
        hold(1'b0, 40);
        present = ~dq;
        hold(1'b0, 80);
    endtask : bus_reset

    // Short low for a one, held low past the sample point for a zero.
    // Slot kept short so a status slot can still catch a busy device.
    task automatic write_bit(input logic b);
        hold(1'b1, 2);
        hold(~b, 22);
        hold(1'b0, 3);
    endtask : write_bit

    task automatic write_byte(input logic [7:0] d);
        for (int i = 0; i < 8; i++) write_bit(d[i]);
    endtask : write_byte

    // Read slots; low held until the device has taken over the line
    task automatic read_bits(input int n, output logic [71:0] v);
        v = '0;
        for (int i = 0; i < n; i++) begin
            hold(1'b1, 4);
            hold(1'b0, 8);
            v[i] = dq;
            hold(1'b0, 14);
        end
    endtask : read_bits
endmodule : swsr_bus_master

/* tb/swsr_device_tb.sv */
`timescale 1ns/1ns
module swsr_device_tb;
    import swsr_pkg::*;
    localparam logic [7:0] FAM = 8'h5a;          // Arbitrary value, the device default
    localparam logic [47:0] SER = 48'h0123456789ab; // Arbitrary value, the device default
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic temp_valid = 1'b0;
    logic ext_powered = 1'b1;
    logic [15:0] temp_in = 16'h0000;
    logic dev_oe, dev_out, m_oe, conv_start, alarm_flag, pres;
    logic conv_seen = 1'b0;
    logic [1:0] resolution_sel;
    logic [71:0] v;
    logic [63:0] id;
    int fails = 0;
    int n_checks = 0;
    // Pull-up wins unless someone drives low
    wire dq = ~m_oe & (dev_oe ? dev_out : 1'b1);

    swsr_device #(.RESET_LOW_CYCLES(200), .SAMPLE_CYCLES(20), .PRES_WAIT_CYCLES(20),
        .PRES_LEN_CYCLES(40), .CONV_MAX_CYCLES(800)) i_swsr_device (.clk(clk),
        .rst_n(rst_n), .dq_in(dq), .dq_out(dev_out), .dq_oe(dev_oe),
        .ext_powered(ext_powered), .temp_in(temp_in),
        .temp_valid(temp_valid), .conv_start(conv_start),
        .resolution_sel(resolution_sel), .alarm_flag(alarm_flag));
    swsr_bus_master i_swsr_bus_master (.clk(clk), .dq(dq), .m_oe(m_oe));

    // Clock and a sticky record of the conversion pulse
    always #2 clk = ~clk;
    always @(posedge clk) if (conv_start) conv_seen <= 1'b1;

    // Independent check byte, lsb first, reflected polynomial
    function automatic logic [7:0] crc8(input logic [71:0] d, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++) c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
        return c;
    endfunction : crc8

    function automatic logic [71:0] sp(input logic [7:0] hi, lo, cfg, input logic [15:0] t);
        logic [63:0] b;
        b = {RSVD_C, RSVD_B, RSVD_A, cfg, lo, hi, t};
        return {crc8({8'h00, b}, 64), b};
    endfunction : sp

    task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // Every access opens with a bus reset and a ROM command
    task automatic open(input logic [7:0] rom);
        i_swsr_bus_master.bus_reset(pres);
        check("presence", {71'h0, pres}, 72'h1);
        i_swsr_bus_master.write_byte(rom);
    endtask : open

    task automatic func(input logic [7:0] rom, input logic [7:0] cmd);
        open(rom);
        i_swsr_bus_master.write_byte(cmd);
    endtask : func

    task automatic read_sp(input logic [71:0] exp);
        func(CMD_SKIP, CMD_READ_SP);
        i_swsr_bus_master.read_bits(72, v);
        check("scratchpad", v, exp);
        check("sp residue", {64'h0, crc8(v, 72)}, 72'h0);
    endtask : read_sp

    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        id = {crc8({16'h0, SER, FAM}, 56), SER, FAM};
        open(CMD_READ_ID);
        i_swsr_bus_master.read_bits(64, v);
        check("identifier", v, {8'h0, id});
        read_sp(sp(NV_UPPER_RESET, NV_LOWER_RESET, 8'h7f, TEMP_RESET));
        check("resolution", {70'h0, resolution_sel}, 72'h3);
        $display("test identifier and defaults done");
        // Write, commit, overwrite, then reload the committed bytes
        func(CMD_SKIP, CMD_WRITE_SP);
        for (int j = 0; j < 3; j++) i_swsr_bus_master.write_byte(8'h00);
        read_sp(sp(8'h00, 8'h00, 8'h1f, TEMP_RESET));
        func(CMD_SKIP, CMD_WRITE_SP);
        i_swsr_bus_master.write_byte(8'h11);
        i_swsr_bus_master.write_byte(8'h22);
        i_swsr_bus_master.write_byte(8'hc0);
        check("resolution", {70'h0, resolution_sel}, 72'h2);
        func(CMD_SKIP, CMD_COPY_SP);
        func(CMD_SKIP, CMD_WRITE_SP);
        for (int j = 0; j < 3; j++) i_swsr_bus_master.write_byte(8'h00);
        // First slot lands while the reload runs, the second after it
        func(CMD_SKIP, CMD_RELOAD_NV);
        i_swsr_bus_master.read_bits(2, v);
        check("reload status", v, 72'h2);
        read_sp(sp(8'h11, 8'h22, 8'h5f, TEMP_RESET));
        $display("test write copy reload done");
        // Exact identifier selects; the low bit flipped in every byte keeps the line released
        for (int k = 0; k < 2; k++) begin
            open(CMD_MATCH);
            for (int j = 0; j < 8; j++) i_swsr_bus_master.write_byte(id[j*8 +: 8] ^ k[7:0]);
            i_swsr_bus_master.write_byte(CMD_READ_SP);
            i_swsr_bus_master.read_bits(8, v);
            check("match", v, k ? 72'hff : 72'h50);
        end
        // Function command without a ROM command is ignored
        open(CMD_READ_SP);
        i_swsr_bus_master.read_bits(8, v);
        check("out of order", v, 72'hff);
        $display("test addressing done");
        // Conversion status, result landing in bytes 0-1, alarm at or below lower limit
        func(CMD_SKIP, CMD_CONVERT);
        check("conv start", {71'h0, conv_seen}, 72'h1);
        i_swsr_bus_master.read_bits(1, v);
        check("busy", v, 72'h0);
        temp_in = 16'h0191;
        temp_valid = 1'b1;
        @(negedge clk);
        temp_valid = 1'b0;
        i_swsr_bus_master.read_bits(1, v);
        check("done", v, 72'h1);
        check("alarm", {71'h0, alarm_flag}, 72'h1);
        read_sp(sp(8'h11, 8'h22, 8'h5f, 16'h0191));
        $display("test conversion done");
        // Supply answer follows the external power input
        for (int p = 0; p < 2; p++) begin
            ext_powered = p[0];
            func(CMD_SKIP, CMD_POWER);
            i_swsr_bus_master.read_bits(1, v);
            check("power", v, {71'h0, p[0]});
        end
        // Alarm flag is set, so an alarm search walks the whole identifier
        open(CMD_ALARM_SEARCH);
        for (int j = 0; j < 64; j++) begin
            i_swsr_bus_master.read_bits(2, v);
            check("search bits", v, {70'h0, ~id[j], id[j]});
            i_swsr_bus_master.write_bit(id[j]);
        end
        // A wrong choice on the first bit leaves the line released
        open(CMD_SEARCH);
        i_swsr_bus_master.read_bits(2, v);
        i_swsr_bus_master.write_bit(~id[0]);
        i_swsr_bus_master.read_bits(2, v);
        check("search loser", v, 72'h3);
        $display("test power and search done");
        results();
    end

    // Watchdog at about twice the expected run
    initial begin
        #270000;
        fails++;
        results();
    end
endmodule : swsr_device_tb
